// *** logic/link_regs_pkg.sv ***
// constants and types for the link configuration and error status registers
`default_nettype none
package link_regs_pkg;
	// register byte offsets
	localparam logic [7:0] ila_multiframe_count_off      = 8'h00;
	localparam logic [7:0] test_pattern_select_off       = 8'h04;
	localparam logic [7:0] link_error_status_off         = 8'h08;
	localparam logic [7:0] octets_per_frame_cfg_off      = 8'h0c;
	localparam logic [7:0] frames_per_multiframe_cfg_off = 8'h10;
	localparam logic [7:0] core_control_off              = 8'h14;
	// reset values
	localparam logic [7:0] ila_multiframe_count_rst      = 8'h03;
	localparam logic [4:0] test_pattern_select_rst       = 5'h00;
	localparam logic [7:0] octets_per_frame_cfg_rst      = 8'h01;
	localparam logic [4:0] frames_per_multiframe_cfg_rst = 5'h1f;
	// field layout
	localparam int         ila_mf_w     = 8;
	localparam int         test_sel_w   = 5;
	localparam int         opf_w        = 8;
	localparam int         fpmf_w       = 5;
	localparam int         prbs_bit     = 4;
	localparam int         align_bit    = 31;
	localparam int         sysref_bit   = 30;
	localparam int         overflow_bit = 29;
	localparam int         lane_count   = 8;
	localparam int         lane_field_w = 3;
	localparam int         ctl_reset_bit = 0;
	localparam int         ctl_wdog_bit  = 1;
	// test mode codes
	localparam logic [4:0] tm_normal = 5'h00;
	localparam logic [4:0] tm_k28    = 5'h01;
	localparam logic [4:0] tm_ila    = 5'h02;
	localparam logic [4:0] tm_d21    = 5'h03;
	localparam logic [4:0] tm_rpat   = 5'h05;
	localparam logic [4:0] tm_jspat  = 5'h07;
	// characters and alarm threshold
	localparam logic [7:0] char_k28_5      = 8'hbc;
	localparam logic [7:0] char_d21_5      = 8'hb5;
	localparam logic [2:0] misalign_limit  = 3'h7;
	// bus answers
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef struct packed {
		logic unexp_k;
		logic disparity;
		logic not_in_table;
	} lane_err_type;

	typedef struct packed {
		logic       is_k;
		logic [7:0] value;
	} char_type;

	typedef enum logic [6:0] {
		pat_normal = 7'h01,
		pat_k28    = 7'h02,
		pat_ila    = 7'h04,
		pat_d21    = 7'h08,
		pat_rpat   = 7'h10,
		pat_jspat  = 7'h20,
		pat_prbs   = 7'h40
	} pattern_type;
endpackage : link_regs_pkg
`default_nettype wire

// *** logic/link_cfg_status_regs.sv ***
// link configuration, test pattern and error status registers
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module link_cfg_status_regs #(
	parameter bit          is_transmit = 1'b1,
	parameter logic [7:0]  lanes_built = 8'hff
) (
	input  wire logic                         mclk,
	input  wire logic                         rst_b,
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output var  logic                         s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output var  logic                         s_axi_wready,
	output var  logic [1:0]                   s_axi_bresp,
	output var  logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [7:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output var  logic                         s_axi_arready,
	output var  logic [31:0]                  s_axi_rdata,
	output var  logic [1:0]                   s_axi_rresp,
	output var  logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         sync_done,
	input  wire logic                         ila_support_en,
	input  wire logic                         subclass1_mode,
	input  wire link_regs_pkg::lane_err_type  lane_err [8],
	input  wire logic [7:0]                   marker_seen,
	input  wire logic [7:0]                   marker_misaligned,
	input  wire logic                         sysref_misaligned,
	input  wire logic                         rx_buf_overflow,
	input  wire logic                         watchdog_clear,
	output var  logic [7:0]                   ila_multiframe_count,
	output var  logic [7:0]                   octets_per_frame,
	output var  logic [4:0]                   frames_per_multiframe,
	output var  link_regs_pkg::pattern_type   pattern,
	output var  link_regs_pkg::char_type      test_char,
	output var  logic                         link_data_en,
	output var  logic                         prbs_en,
	output var  logic [3:0]                   prbs_sel,
	output var  logic                         ila_active,
	output var  logic                         ila_repeat,
	output var  logic                         core_reset
);
	import link_regs_pkg::*;

	// next misalignment run length of one lane, saturating at the limit
	function automatic logic [2:0] next_run(input logic [2:0] run,
		input logic seen, input logic mis);
		logic [2:0] result;
		result = run;
		if (seen && !mis) begin
			result = 3'h0;
		end else if (seen && mis && run != misalign_limit) begin
			result = 3'(run + 3'h1);
		end
		return result;
	endfunction : next_run

	// word select of a byte address; false for unaligned or unmapped
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] off);
		return addr == off;
	endfunction : hit

	logic [7:0]  ila_mf_reg;
	logic [4:0]  test_sel_reg;
	logic [7:0]  opf_reg;
	logic [4:0]  fpmf_reg;
	logic        wdog_en_reg;
	logic        core_reset_reg;
	logic [31:0] err_status_reg;
	logic [2:0]  run_reg [8];
	logic [2:0]  run_next [8];

	logic        awready_reg;
	logic        wready_reg;
	logic        aw_have_reg;
	logic        w_have_reg;
	logic [7:0]  waddr_reg;
	logic [31:0] wdata_reg;
	logic        wstrb0_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	pattern_type pattern_reg;
	char_type    test_char_reg;
	logic        link_data_en_reg;
	logic        prbs_en_reg;
	logic [3:0]  prbs_sel_reg;
	logic        ila_active_reg;
	logic        ila_repeat_reg;

	// bus handshakes
	wire logic aw_take  = s_axi_awvalid & awready_reg;
	wire logic w_take   = s_axi_wvalid & wready_reg;
	wire logic ar_take  = s_axi_arvalid & arready_reg;
	wire logic do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
	wire logic bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
	wire logic aw_have_next = (aw_have_reg | aw_take) & ~do_write;
	wire logic w_have_next  = (w_have_reg | w_take) & ~do_write;
	wire logic rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);

	// write decode
	wire logic wr_ila  = hit(waddr_reg, ila_multiframe_count_off);
	wire logic wr_test = hit(waddr_reg, test_pattern_select_off);
	wire logic wr_stat = hit(waddr_reg, link_error_status_off);
	wire logic wr_opf  = hit(waddr_reg, octets_per_frame_cfg_off);
	wire logic wr_fpmf = hit(waddr_reg, frames_per_multiframe_cfg_off);
	wire logic wr_ctl  = hit(waddr_reg, core_control_off);
	wire logic wr_map  = wr_ila | wr_test | wr_stat | wr_opf | wr_fpmf
		| wr_ctl;
	wire logic wr_en   = do_write & wstrb0_reg;

	// read decode and mux
	wire logic rd_ila  = hit(s_axi_araddr, ila_multiframe_count_off);
	wire logic rd_test = hit(s_axi_araddr, test_pattern_select_off);
	wire logic rd_stat = hit(s_axi_araddr, link_error_status_off);
	wire logic rd_opf  = hit(s_axi_araddr, octets_per_frame_cfg_off);
	wire logic rd_fpmf = hit(s_axi_araddr, frames_per_multiframe_cfg_off);
	wire logic rd_ctl  = hit(s_axi_araddr, core_control_off);
	wire logic rd_map  = rd_ila | rd_test | rd_stat | rd_opf | rd_fpmf
		| rd_ctl;
	wire logic [31:0] rd_mux =
		rd_ila  ? {24'h0, ila_mf_reg} :
		rd_test ? {27'h0, test_sel_reg} :
		rd_stat ? err_status_reg :
		rd_opf  ? {24'h0, opf_reg} :
		rd_fpmf ? {27'h0, fpmf_reg} :
		rd_ctl  ? {30'h0, wdog_en_reg, core_reset_reg} : 32'h0;

	// test pattern decode; transmit-only codes fall back on a receiver
	wire logic tx_only_code = test_sel_reg[prbs_bit]
		| test_sel_reg == tm_d21 | test_sel_reg == tm_rpat
		| test_sel_reg == tm_jspat;
	wire pattern_type pat_next =
		(!is_transmit && tx_only_code) ? pat_normal :
		test_sel_reg[prbs_bit]   ? pat_prbs :
		test_sel_reg == tm_k28   ? pat_k28 :
		test_sel_reg == tm_ila   ? pat_ila :
		test_sel_reg == tm_d21   ? pat_d21 :
		test_sel_reg == tm_rpat  ? pat_rpat :
		test_sel_reg == tm_jspat ? pat_jspat : pat_normal;

	// error capture gating
	wire logic capture_en = sync_done
		& ~(!is_transmit && tx_only_code);
	wire logic stat_clear = (ar_take & rd_stat)
		| core_reset_reg
		| (wdog_en_reg & watchdog_clear);

	logic [23:0] lane_set;
	logic        align_set;
	always_comb begin
		lane_set  = 24'h0;
		align_set = 1'b0;
		for (int i = 0; i < lane_count; i++) begin
			run_next[i] = next_run(run_reg[i], marker_seen[i],
				marker_misaligned[i]);
			if (lanes_built[i]) begin
				lane_set[i*lane_field_w +: lane_field_w] =
					lane_err[i];
				if (marker_seen[i] && marker_misaligned[i]
					&& run_next[i] == misalign_limit) begin
					align_set = 1'b1;
				end
			end
		end
	end

	wire logic [31:0] set_vec = capture_en ? {
		align_set,
		sysref_misaligned & subclass1_mode,
		rx_buf_overflow,
		5'h00,
		lane_set} : 32'h0;
	// a new event in the clearing cycle survives the clear
	wire logic [31:0] err_status_next =
		(stat_clear ? 32'h0 : err_status_reg) | set_vec;

	// write channel
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= resp_okay;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			awready_reg <= ~aw_have_next & ~bvalid_next;
			wready_reg  <= ~w_have_next & ~bvalid_next;
			bvalid_reg  <= bvalid_next;
			if (do_write) begin
				bresp_reg <= wr_map ? resp_okay : resp_slverr;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			waddr_reg  <= 8'h00;
			wdata_reg  <= 32'h0;
			wstrb0_reg <= 1'b0;
		end else begin
			if (aw_take) begin
				waddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_reg  <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
		end
	end

	// read channel
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= resp_okay;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_mux;
				rresp_reg <= rd_map ? resp_okay : resp_slverr;
			end
		end
	end

	// configuration registers, kept across a core reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ila_mf_reg   <= ila_multiframe_count_rst;
			test_sel_reg <= test_pattern_select_rst;
			opf_reg      <= octets_per_frame_cfg_rst;
			fpmf_reg     <= frames_per_multiframe_cfg_rst;
			wdog_en_reg  <= 1'b0;
		end else if (wr_en) begin
			if (wr_ila) begin
				ila_mf_reg <= wdata_reg[ila_mf_w-1:0];
			end
			if (wr_test) begin
				test_sel_reg <= wdata_reg[test_sel_w-1:0];
			end
			if (wr_opf) begin
				opf_reg <= wdata_reg[opf_w-1:0];
			end
			if (wr_fpmf) begin
				fpmf_reg <= wdata_reg[fpmf_w-1:0];
			end
			if (wr_ctl) begin
				wdog_en_reg <= wdata_reg[ctl_wdog_bit];
			end
		end
	end

	// one-cycle core reset pulse, status and alignment tracking
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			core_reset_reg <= 1'b0;
			err_status_reg <= 32'h0;
			for (int i = 0; i < lane_count; i++) begin
				run_reg[i] <= 3'h0;
			end
		end else begin
			core_reset_reg <= wr_en & wr_ctl
				& wdata_reg[ctl_reset_bit];
			err_status_reg <= err_status_next;
			for (int i = 0; i < lane_count; i++) begin
				run_reg[i] <= (core_reset_reg || !sync_done) ? 3'h0
					: run_next[i];
			end
		end
	end

	// link-facing pattern and ila controls
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pattern_reg      <= pat_normal;
			test_char_reg    <= '0;
			link_data_en_reg <= 1'b1;
			prbs_en_reg      <= 1'b0;
			prbs_sel_reg     <= 4'h0;
			ila_active_reg   <= 1'b0;
			ila_repeat_reg   <= 1'b0;
		end else begin
			pattern_reg      <= pat_next;
			link_data_en_reg <= pat_next != pat_prbs;
			prbs_en_reg      <= pat_next == pat_prbs;
			prbs_sel_reg     <= (pat_next == pat_prbs)
				? test_sel_reg[3:0] : 4'h0;
			ila_active_reg   <= ila_support_en
				& (pat_next == pat_normal || pat_next == pat_ila);
			ila_repeat_reg   <= (pat_next == pat_ila) & sync_done;
			case (pat_next)
				pat_k28: begin
					test_char_reg <= '{is_k: 1'b1,
						value: char_k28_5};
				end
				pat_d21: begin
					test_char_reg <= '{is_k: 1'b0,
						value: char_d21_5};
				end
				default: begin
					test_char_reg <= '0;
				end
			endcase
		end
	end

	assign s_axi_awready         = awready_reg;
	assign s_axi_wready          = wready_reg;
	assign s_axi_bvalid          = bvalid_reg;
	assign s_axi_bresp           = bresp_reg;
	assign s_axi_arready         = arready_reg;
	assign s_axi_rvalid          = rvalid_reg;
	assign s_axi_rdata           = rdata_reg;
	assign s_axi_rresp           = rresp_reg;
	assign ila_multiframe_count       = ila_mf_reg;
	assign octets_per_frame      = opf_reg;
	assign frames_per_multiframe = fpmf_reg;
	assign pattern               = pattern_reg;
	assign test_char             = test_char_reg;
	assign link_data_en          = link_data_en_reg;
	assign prbs_en               = prbs_en_reg;
	assign prbs_sel              = prbs_sel_reg;
	assign ila_active            = ila_active_reg;
	assign ila_repeat            = ila_repeat_reg;
	assign core_reset            = core_reset_reg;
endmodule : link_cfg_status_regs
`default_nettype wire

// *** dv/link_cfg_status_regs_monitor.sv ***
// port checker for the link register block
`timescale 1ns/100ps
`default_nettype none
module link_cfg_status_regs_monitor #(
	parameter logic [7:0] lanes_built = 8'hff
) (
	input wire logic                        mclk,
	input wire logic                        rst_b,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_rvalid,
	input wire logic [31:0]                 s_axi_rdata,
	input wire logic                        sync_done,
	input wire logic                        ila_support_en,
	input wire logic [7:0]                  ila_multiframe_count,
	input wire link_regs_pkg::pattern_type  pattern,
	input wire link_regs_pkg::char_type     test_char,
	input wire logic                        link_data_en,
	input wire logic                        prbs_en,
	input wire logic                        ila_active,
	input wire logic                        ila_repeat,
	input wire logic                        core_reset
);
	import link_regs_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_NORMAL: assert property (pattern == pat_normal |->
		link_data_en && !prbs_en && test_char == 9'h000)
		else $error("normal mode outputs wrong");
	AST_K28: assert property (pattern == pat_k28 |->
		test_char == {1'b1, char_k28_5}) else $error("k28 char wrong");
	AST_ILA_REPEAT: assert property (ila_repeat |->
		pattern == pat_ila && $past(sync_done))
		else $error("ila repeat without cause");
	AST_D21: assert property (pattern == pat_d21 |->
		test_char == {1'b0, char_d21_5}) else $error("d21 char wrong");
	AST_PRBS: assert property (prbs_en |->
		!link_data_en && pattern == pat_prbs)
		else $error("prbs mode left data on");
	AST_RSVD: assert property (s_axi_rvalid |->
		s_axi_rdata[28:24] == 5'h00) else $error("reserved bits set");
	AST_UNBUILT: assert property (s_axi_rvalid && !lanes_built[7] |->
		s_axi_rdata[23:21] == 3'h0) else $error("unbuilt lane reports");
	AST_ILA_ACT: assert property (ila_active |-> $past(ila_support_en) &&
		(pattern == pat_normal || pattern == pat_ila))
		else $error("ila active without support");
	AST_CFG_UPD: assert property ($changed(ila_multiframe_count) |->
		$rose(s_axi_bvalid)) else $error("config changed without write");
	AST_CORE_RST_PULSE: assert property (core_reset |=> !core_reset)
		else $error("core reset longer than one cycle");
	cover property (pattern == pat_prbs);
	cover property (ila_repeat);
	cover property ($rose(core_reset));
endmodule : link_cfg_status_regs_monitor
bind link_cfg_status_regs link_cfg_status_regs_monitor #(
	.lanes_built(lanes_built)
) u_monitor (.*);
`default_nettype wire

// *** dv/link_cfg_status_regs_tb_top.sv ***
// self-checking bench for the link register block
`timescale 1ns/100ps
`default_nettype none
module link_cfg_status_regs_tb_top;
	import link_regs_pkg::*;
	logic         mclk = 1'b0;
	logic         rst_b = 1'b0;
	logic [7:0]   s_axi_awaddr, s_axi_araddr, marker_seen, marker_misaligned;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb, prbs_sel;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready, sync_done, ila_support_en;
	logic         subclass1_mode, sysref_misaligned, rx_buf_overflow;
	logic         watchdog_clear, link_data_en, prbs_en, ila_active;
	logic         ila_repeat, core_reset;
	logic [7:0]   ila_multiframe_count, octets_per_frame;
	logic [4:0]   frames_per_multiframe;
	lane_err_type lane_err [8];
	pattern_type  pattern;
	char_type     test_char;
	int           num_errors = 0;
	int           n_checks = 0;
	int           core_reset_cycles = 0;
	always #4 mclk = ~mclk;
	// counts cycles in which the core reset pulse stands
	always @(posedge mclk) begin
		if (rst_b && core_reset === 1'b1)
			core_reset_cycles <= core_reset_cycles + 1;
	end
	link_cfg_status_regs #(.lanes_built(8'h7f)) DUT (.*);
	task automatic end_sim;
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang;
		num_errors++;
		$display("[ERR] %0t bus timeout", $time);
		end_sim();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				done = 1'b1;
				s_axi_bready <= 1'b0;
				chk({30'h0, s_axi_bresp}, {30'h0, er});
			end
		end
		if (!done) hang();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				done = 1'b1;
				s_axi_rready <= 1'b0;
				chk(s_axi_rdata, ed);
				chk({30'h0, s_axi_rresp}, {30'h0, er});
			end
		end
		if (!done) hang();
	endtask : rd
	// one-cycle pulse on lanes 0, 2, 7 and the alarm inputs
	task automatic ev(input lane_err_type a, b, c, input logic s, o);
		@(posedge mclk);
		lane_err[0] <= a;
		lane_err[2] <= b;
		lane_err[7] <= c;
		sysref_misaligned <= s;
		rx_buf_overflow <= o;
		@(posedge mclk);
		lane_err[0] <= '0;
		lane_err[2] <= '0;
		lane_err[7] <= '0;
		sysref_misaligned <= 1'b0;
		rx_buf_overflow <= 1'b0;
	endtask : ev
	task automatic mk(input int n, input logic m);
		repeat (n) begin
			@(posedge mclk);
			marker_seen <= 8'h02;
			marker_misaligned <= {6'h0, m, 1'b0};
		end
		@(posedge mclk);
		marker_seen <= 8'h00;
		marker_misaligned <= 8'h00;
	endtask : mk
	task automatic wd;
		@(posedge mclk);
		watchdog_clear <= 1'b1;
		@(posedge mclk);
		watchdog_clear <= 1'b0;
	endtask : wd
	task automatic t_reset;
		rd(ila_multiframe_count_off, 32'h3, resp_okay);
		rd(test_pattern_select_off, 32'h0, resp_okay);
		rd(octets_per_frame_cfg_off, 32'h1, resp_okay);
		rd(frames_per_multiframe_cfg_off, 32'h1f, resp_okay);
		rd(link_error_status_off, 32'h0, resp_okay);
	endtask : t_reset
	task automatic t_cfg;
		wr(ila_multiframe_count_off, 32'hffff_ffff, resp_okay);
		wr(octets_per_frame_cfg_off, 32'hffff_ff07, resp_okay);
		wr(frames_per_multiframe_cfg_off, 32'hffff_ffef, resp_okay);
		rd(ila_multiframe_count_off, 32'hff, resp_okay);
		rd(octets_per_frame_cfg_off, 32'h07, resp_okay);
		rd(frames_per_multiframe_cfg_off, 32'h0f, resp_okay);
		chk({11'h0, ila_multiframe_count, octets_per_frame, frames_per_multiframe},
			{11'h0, 8'hff, 8'h07, 5'h0f});
		wr(8'h18, 32'h1, resp_slverr);
		rd(8'h18, 32'h0, resp_slverr);
	endtask : t_cfg
	task automatic t_modes;
		logic [4:0] c [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h12};
		logic [6:0] p [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
		logic [8:0] k [7] = '{9'h0, 9'h1bc, 9'h0, 9'h0b5, 9'h0, 9'h0, 9'h0};
		for (int i = 0; i < 7; i++) begin
			wr(test_pattern_select_off, {27'h0, c[i]}, resp_okay);
			repeat (2) @(posedge mclk);
			#1;
			chk({8'h0, prbs_sel, pattern, test_char, link_data_en, prbs_en,
				ila_repeat, ila_active}, {8'h0, c[i][4] ? c[i][3:0] : 4'h0,
				p[i], k[i], ~c[i][4], c[i][4], i == 2,
				i == 0 || i == 2});
		end
		wr(test_pattern_select_off, 32'h0, resp_okay);
	endtask : t_modes
	task automatic t_errs;
		@(posedge mclk);
		sync_done <= 1'b0;
		ev(3'b111, 3'b111, 3'b000, 1'b1, 1'b1);
		@(posedge mclk);
		sync_done <= 1'b1;
		rd(link_error_status_off, 32'h0, resp_okay);
		ev(3'b101, 3'b010, 3'b111, 1'b1, 1'b0);
		ev(3'b000, 3'b000, 3'b000, 1'b0, 1'b1);
		rd(link_error_status_off, 32'h6000_0085, resp_okay);
		rd(link_error_status_off, 32'h0, resp_okay);
	endtask : t_errs
	task automatic t_align;
		mk(6, 1'b1);
		mk(1, 1'b0);
		mk(6, 1'b1);
		rd(link_error_status_off, 32'h0, resp_okay);
		mk(1, 1'b1);
		rd(link_error_status_off, 32'h8000_0000, resp_okay);
		rd(link_error_status_off, 32'h0, resp_okay);
	endtask : t_align
	task automatic t_clear;
		ev('0, '0, '0, 1'b0, 1'b1);
		wr(core_control_off, 32'h1, resp_okay);
		rd(link_error_status_off, 32'h0, resp_okay);
		rd(ila_multiframe_count_off, 32'hff, resp_okay);
		chk(core_reset_cycles, 32'h1);
		ev('0, '0, '0, 1'b0, 1'b1);
		wd();
		rd(link_error_status_off, 32'h2000_0000, resp_okay);
		wr(core_control_off, 32'h2, resp_okay);
		ev('0, '0, '0, 1'b0, 1'b1);
		wd();
		rd(link_error_status_off, 32'h0, resp_okay);
		chk(core_reset_cycles, 32'h1);
	endtask : t_clear
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{marker_seen, marker_misaligned} = 16'h0;
		{sysref_misaligned, rx_buf_overflow, watchdog_clear} = 3'h0;
		{sync_done, ila_support_en, subclass1_mode} = 3'h7;
		foreach (lane_err[i]) lane_err[i] = '0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_cfg();
		t_modes();
		t_errs();
		t_align();
		t_clear();
		end_sim();
	end
endmodule : link_cfg_status_regs_tb_top
`default_nettype wire
